// ===== shared/pmbus_xfer_pkg.sv
// Package with constants, states and carriers for the PMBus slave transfer state machine.
package pmbus_xfer_pkg;

  // ****************************************************************
  // Sizes and codes
  // ****************************************************************
  localparam int        LEN_W          = 8;
  localparam logic [7:0] RX_ARM_LEN    = 8'h23;  // Block write maximum of 35 bytes.
  localparam logic [7:0] SKIP_LIMIT    = 8'h01;
  localparam logic [1:0] ERR_ARBITRATION = 2'h1;
  localparam logic [1:0] ERR_NACK        = 2'h2;
  localparam logic [1:0] ERR_UNEXPECTED  = 2'h3;

  // ****************************************************************
  // States and carriers
  // ****************************************************************
  typedef enum logic [6:0] {
    ST_WAIT_START = 7'h01,
    ST_RX_DATA    = 7'h02,
    ST_RX_STOP    = 7'h04,
    ST_TX_DATA    = 7'h08,
    ST_TX_END     = 7'h10,
    ST_TX_STOP    = 7'h20
  } xfer_state_e;

  typedef struct packed {
    logic startSeen;     // Start condition detected.
    logic stopSeen;      // Stop condition detected.
    logic rxFull;        // Receive buffer full.
    logic txEmpty;       // Transmit buffer empty.
    logic txEnd;         // Transmit end.
    logic nack;          // NACK detected.
    logic arbLost;       // Arbitration lost.
    logic timeout;       // Bus timeout, ignored here.
  } bus_evt_s;

  typedef struct packed {
    logic       rxNotify;
    logic       rxEnd;
    logic       txNotify;
    logic       txDone;
    logic       startNotify;
    logic       errValid;
    logic [1:0] errCode;
  } notify_s;

endpackage

// ===== design/pmbus_slave_transfer_fsm.sv
// Transfer state machine of a PMBus slave between bus events and the upper layer.
`timescale 1ns/10ps
module pmbus_slave_transfer_fsm
  import pmbus_xfer_pkg::*;
#(
  parameter int LW = LEN_W
) (
  input  wire logic          clk,
  input  wire logic          sys_rst,
  input  wire bus_evt_s      busEvt,
  input  wire logic          startSeenFlag,
  input  wire logic          stopSeenFlag,
  input  wire logic          sendReq,
  input  wire logic          recvReq,
  input  wire logic [LW-1:0] reqLen,
  input  wire logic          araMode,
  output logic               dirTx,
  output logic [LW-1:0]      byteCount,
  output logic [LW-1:0]      skipCount,
  output logic [6:0]         stateOut,
  output logic               rxArm,
  output logic               txArm,
  output notify_s            notify
);

  // ****************************************************************
  // State and counters
  // ****************************************************************
  xfer_state_e   state_r;
  logic [LW-1:0] len_r;
  logic [LW-1:0] remain;

  assign remain = len_r - byteCount;

  // True when the byte about to be counted completes the requested length.
  function automatic logic lastByte(input logic [LW-1:0] count, input logic [LW-1:0] limit);
    return (count + 1'b1) == limit;
  endfunction

  // Outputs expose state directly from flip-flops.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stateOut <= 7'h01;
    end else begin
      stateOut <= state_r;
    end
  end

  // Main sequencing; requests win over every bus event.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r   <= ST_WAIT_START;
      dirTx     <= 1'b0;
      len_r     <= LW'(RX_ARM_LEN);
      byteCount <= '0;
      skipCount <= '0;
      rxArm     <= 1'b0;
      txArm     <= 1'b0;
      notify    <= '0;
    end else begin
      notify <= '0;
      rxArm  <= 1'b0;
      txArm  <= 1'b0;
      if (sendReq || recvReq) begin
        state_r   <= ST_WAIT_START;
        dirTx     <= sendReq;
        len_r     <= reqLen;
        byteCount <= '0;
        skipCount <= '0;
      end else begin
        // No branch decodes the bus timeout pulse; an outer monitor owns timeouts.
        unique case (state_r)
          ST_WAIT_START: begin
            if (busEvt.startSeen) begin
              state_r <= dirTx ? ST_TX_DATA : ST_RX_DATA;
              notify.startNotify <= 1'b1;
            end
          end
          ST_RX_DATA: begin
            if (busEvt.stopSeen) begin
              state_r       <= ST_WAIT_START;
              notify.rxEnd  <= 1'b1;
              rxArm         <= 1'b1;
              len_r         <= LW'(RX_ARM_LEN);
              byteCount     <= '0;
            end else if (busEvt.txEmpty && startSeenFlag) begin
              notify.txNotify <= 1'b1;
              dirTx           <= 1'b1;
              state_r         <= ST_TX_DATA;
              byteCount       <= '0;
            end else if (busEvt.rxFull) begin
              byteCount <= byteCount + 1'b1;
              if (skipCount < LW'(SKIP_LIMIT)) begin
                notify.rxNotify <= 1'b1;
              end
              if (lastByte(byteCount, len_r)) begin
                state_r         <= ST_RX_STOP;
                notify.rxNotify <= 1'b1;
              end
            end else if (busEvt.arbLost) begin
              notify.errValid <= 1'b1;
              notify.errCode  <= ERR_ARBITRATION;
            end else if (busEvt.nack) begin
              notify.errValid <= 1'b1;
              notify.errCode  <= ERR_NACK;
            end
          end
          ST_RX_STOP: begin
            if (busEvt.stopSeen) begin
              state_r      <= ST_WAIT_START;
              notify.rxEnd <= 1'b1;
              rxArm        <= 1'b1;
              len_r        <= LW'(RX_ARM_LEN);
              byteCount    <= '0;
            end else if (busEvt.arbLost) begin
              notify.errValid <= 1'b1;
              notify.errCode  <= ERR_ARBITRATION;
            end else if (busEvt.nack) begin
              notify.errValid <= 1'b1;
              notify.errCode  <= ERR_NACK;
            end else if (busEvt.rxFull) begin
              notify.errValid <= 1'b1;
              notify.errCode  <= ERR_UNEXPECTED;
            end
          end
          ST_TX_DATA, ST_TX_END, ST_TX_STOP: begin
            if (busEvt.nack) begin
              if (remain == '0) begin
                state_r <= ST_TX_STOP;
              end else begin
                notify.txDone   <= 1'b1;
                notify.errValid <= 1'b1;
                notify.errCode  <= ERR_NACK;
                rxArm           <= ~araMode;
                txArm           <= araMode;
              end
            end else if (busEvt.arbLost) begin
              notify.errValid <= 1'b1;
              notify.errCode  <= ERR_ARBITRATION;
            end else if (state_r == ST_TX_DATA) begin
              if (busEvt.stopSeen) begin
                state_r <= ST_WAIT_START;
              end else if (busEvt.txEmpty) begin
                if (remain == '0) begin
                  state_r <= ST_TX_END;
                end else begin
                  byteCount <= byteCount + 1'b1;
                end
              end
            end else if (state_r == ST_TX_END) begin
              if (busEvt.txEnd) begin
                state_r <= ST_TX_STOP;
              end else if (busEvt.startSeen || busEvt.stopSeen) begin
                notify.errValid <= 1'b1;
                notify.errCode  <= ERR_UNEXPECTED;
              end
            end else if (busEvt.stopSeen) begin
              notify.txDone <= 1'b1;
              rxArm         <= ~araMode;
              txArm         <= araMode;
            end
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_rx_stop_rearm: assert property (@(posedge clk) disable iff (sys_rst)
    (state_r == ST_RX_DATA && busEvt.stopSeen && !sendReq && !recvReq)
      |=> (state_r == ST_WAIT_START && notify.rxEnd && rxArm))
    else $error("Receive stop did not re-arm.");
  chk_rx_full_stop: assert property (@(posedge clk) disable iff (sys_rst)
    (state_r == ST_RX_STOP && busEvt.stopSeen && !sendReq && !recvReq) |=> rxArm && notify.rxEnd)
    else $error("Full receive stop did not re-arm.");
  chk_rx_len_reach: assert property (@(posedge clk) disable iff (sys_rst)
    (state_r == ST_RX_DATA && busEvt.rxFull && !busEvt.stopSeen && !(busEvt.txEmpty && startSeenFlag)
     && !sendReq && !recvReq && lastByte(byteCount, len_r)) |=> state_r == ST_RX_STOP && notify.rxNotify)
    else $error("Length reached without receive stop.");
  chk_restart_tx: assert property (@(posedge clk) disable iff (sys_rst)
    (state_r == ST_RX_DATA && busEvt.txEmpty && startSeenFlag && !busEvt.stopSeen && !sendReq && !recvReq)
      |=> dirTx && state_r == ST_TX_DATA && notify.txNotify)
    else $error("Repeated start did not switch to transmit.");
  chk_req_return: assert property (@(posedge clk) disable iff (sys_rst)
    (sendReq || recvReq) |=> state_r == ST_WAIT_START && dirTx == $past(sendReq))
    else $error("Request did not return to wait.");
  chk_nack_code: assert property (@(posedge clk) disable iff (sys_rst)
    (state_r == ST_TX_DATA && busEvt.nack && remain != '0 && !sendReq && !recvReq)
      |=> notify.errValid && notify.errCode == ERR_NACK && notify.txDone)
    else $error("NACK with bytes left not reported.");
  chk_nack_stop: assert property (@(posedge clk) disable iff (sys_rst)
    (state_r == ST_TX_DATA && busEvt.nack && remain == '0 && !sendReq && !recvReq) |=> state_r == ST_TX_STOP)
    else $error("NACK at end did not go to send-stop.");
  chk_tx_rearm: assert property (@(posedge clk) disable iff (sys_rst)
    notify.txDone |-> (rxArm == !$past(araMode)) && (txArm == $past(araMode)))
    else $error("Transmit end re-arm mode wrong.");
  chk_empty_end: assert property (@(posedge clk) disable iff (sys_rst)
    (state_r == ST_TX_DATA && busEvt.txEmpty && remain == '0 && !busEvt.nack && !busEvt.arbLost
     && !busEvt.stopSeen && !sendReq && !recvReq) |=> state_r == ST_TX_END)
    else $error("Empty buffer did not advance to send-end.");
  chk_unexp_hold: assert property (@(posedge clk) disable iff (sys_rst)
    (state_r == ST_TX_END && busEvt.startSeen && !busEvt.txEnd && !busEvt.nack && !busEvt.arbLost
     && !sendReq && !recvReq) |=> state_r == ST_TX_END && notify.errCode == ERR_UNEXPECTED)
    else $error("Unexpected event changed state.");

  // ****************************************************************
  // Further checks on posture, counting and error reporting
  // ****************************************************************

  // Reset leaves the machine idle in receive with no pulses.
  chk_reset_idle: assert property (@(posedge clk)
    sys_rst
      |=> state_r == ST_WAIT_START && !dirTx && notify == '0)
    else $error("Reset did not leave the idle receive posture.");

  // The state output follows the internal state one cycle later.
  chk_state_mirror: assert property (@(posedge clk) disable iff (sys_rst)
    1'b1
      |=> stateOut == $past(state_r))
    else $error("State output does not follow the state.");

  // A one-hot state register never takes the unused seventh one-hot code 7'h40.
  chk_onehot_state: assert property (@(posedge clk) disable iff (sys_rst)
    $onehot(state_r)
      |-> state_r != 7'h40)
    else $error("State left the one-hot set.");

  // A request loads its length and clears the byte count.
  chk_len_load: assert property (@(posedge clk) disable iff (sys_rst)
    (sendReq || recvReq)
      |=> len_r == $past(reqLen) && byteCount == '0)
    else $error("Request length not loaded.");

  // A start while armed for receive enters receive-data.
  chk_start_rx: assert property (@(posedge clk) disable iff (sys_rst)
    (state_r == ST_WAIT_START && busEvt.startSeen && !dirTx && !sendReq && !recvReq)
      |=> state_r == ST_RX_DATA && notify.startNotify)
    else $error("Start did not enter receive-data.");

  // A start while armed for transmit enters send-data.
  chk_start_tx: assert property (@(posedge clk) disable iff (sys_rst)
    (state_r == ST_WAIT_START && busEvt.startSeen && dirTx && !sendReq && !recvReq)
      |=> state_r == ST_TX_DATA && notify.startNotify)
    else $error("Start did not enter send-data.");

  // Every counted byte below the skip limit gives a receive notification.
  chk_rx_byte_note: assert property (@(posedge clk) disable iff (sys_rst)
    (state_r == ST_RX_DATA && busEvt.rxFull && !busEvt.stopSeen && !(busEvt.txEmpty && startSeenFlag)
     && skipCount < LW'(SKIP_LIMIT) && !sendReq && !recvReq) |=> notify.rxNotify && byteCount == $past(byteCount) + 1'b1)
    else $error("Received byte not notified or counted.");

  // A repeated start restarts the count for the transmit phase.
  chk_restart_note: assert property (@(posedge clk) disable iff (sys_rst)
    (state_r == ST_RX_DATA && busEvt.txEmpty && startSeenFlag && !busEvt.stopSeen && !sendReq && !recvReq)
      |=> notify.txNotify && byteCount == '0)
    else $error("Repeated start did not raise the send event.");

  // Every receive-end re-arm restores the full block length.
  chk_rx_arm_len: assert property (@(posedge clk) disable iff (sys_rst)
    (rxArm && notify.rxEnd)
      |-> len_r == LW'(RX_ARM_LEN) && byteCount == '0)
    else $error("Receive re-arm lost the full length.");

  // A stray byte after the last one keeps receive-stop and reports an error.
  chk_rx_stop_unexp: assert property (@(posedge clk) disable iff (sys_rst)
    (state_r == ST_RX_STOP && busEvt.rxFull && !busEvt.stopSeen && !busEvt.arbLost && !busEvt.nack
     && !sendReq && !recvReq) |=> state_r == ST_RX_STOP && notify.errValid && notify.errCode == ERR_UNEXPECTED)
    else $error("Stray byte in receive-stop not reported.");

  // A lone timeout pulse changes nothing.
  chk_timeout_ignore: assert property (@(posedge clk) disable iff (sys_rst)
    ($onehot(busEvt) && busEvt.timeout && !sendReq && !recvReq)
      |=> $stable(state_r) && notify == '0 && !rxArm && !txArm)
    else $error("Timeout pulse was acted on.");

  // Arbitration loss while transmitting is reported and keeps the state.
  chk_arb_code_tx: assert property (@(posedge clk) disable iff (sys_rst)
    ((state_r == ST_TX_DATA || state_r == ST_TX_END || state_r == ST_TX_STOP) && busEvt.arbLost && !busEvt.nack
     && !sendReq && !recvReq) |=> $stable(state_r) && notify.errValid && notify.errCode == ERR_ARBITRATION)
    else $error("Arbitration loss not reported.");

  // Each emptied buffer with bytes left counts one sent byte.
  chk_tx_count: assert property (@(posedge clk) disable iff (sys_rst)
    (state_r == ST_TX_DATA && busEvt.txEmpty && remain != '0 && !busEvt.nack && !busEvt.arbLost
     && !busEvt.stopSeen && !sendReq && !recvReq) |=> byteCount == $past(byteCount) + 1'b1)
    else $error("Sent byte not counted.");

  // A stop in send-stop reports transmit end with exactly one re-arm.
  chk_tx_stop_done: assert property (@(posedge clk) disable iff (sys_rst)
    (state_r == ST_TX_STOP && busEvt.stopSeen && !busEvt.nack && !busEvt.arbLost && !sendReq && !recvReq)
      |=> notify.txDone && (rxArm != txArm))
    else $error("Transmit end at stop not reported.");

  // The two re-arm pulses never rise together.
  chk_arm_exclusive: assert property (@(posedge clk) disable iff (sys_rst)
    rxArm
      |-> !txArm)
    else $error("Both re-arm pulses raised.");

  cov_rx_done:  cover property (@(posedge clk) state_r == ST_RX_STOP ##[1:40] notify.rxEnd);
  cov_restart:  cover property (@(posedge clk) state_r == ST_RX_DATA ##1 state_r == ST_TX_DATA);
  cov_tx_done:  cover property (@(posedge clk) notify.txDone);
  cov_arb:      cover property (@(posedge clk) notify.errCode == ERR_ARBITRATION);
  cov_nack:     cover property (@(posedge clk) notify.txDone && notify.errCode == ERR_NACK);

endmodule

// ===== sim/pmbus_master_model.sv
// Behavioural model of the bus master side, seen as the slave interface's event pulses and flags.
`timescale 1ns/10ps
module pmbus_master_model
  import pmbus_xfer_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] evtReq,
  output bus_evt_s        busEvt,
  output logic            startSeenFlag,
  output logic            stopSeenFlag
);
  // Each requested bus event reaches the slave one cycle later, for as many cycles as it is requested.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busEvt <= '0;
    end else begin
      busEvt <= bus_evt_s'(evtReq);
    end
  end

  // The start flag stays up from a start until the next stop, and the stop flag the other way round.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      startSeenFlag <= 1'b0;
      stopSeenFlag  <= 1'b1;
    end else if (evtReq[7]) begin
      startSeenFlag <= 1'b1;
      stopSeenFlag  <= 1'b0;
    end else if (evtReq[6]) begin
      startSeenFlag <= 1'b0;
      stopSeenFlag  <= 1'b1;
    end
  end
endmodule

// ===== sim/test_pmbus_slave_transfer_fsm.sv
// Self-checking testbench for the PMBus slave transfer state machine.
`timescale 1ns/10ps
module test_pmbus_slave_transfer_fsm
  import pmbus_xfer_pkg::*;
;
  typedef struct packed {
    logic [7:0] ev;
    logic [2:0] sra;
    logic [7:0] len;
    logic [7:0] nt;
    logic [1:0] arm;
    logic [6:0] st;
    logic       dir;
    logic [7:0] cnt;
  } row_s;

  logic       clk = 1'b0;
  logic       sysRst = 1'b1;
  logic [7:0] evtReq = 8'h00;
  logic       sendReq = 1'b0;
  logic       recvReq = 1'b0;
  logic [7:0] reqLen = 8'h00;
  logic       araMode = 1'b0;
  bus_evt_s   busEvt;
  logic       startSeenFlag;
  logic       stopSeenFlag;
  logic       dirTx;
  logic [7:0] byteCount;
  logic [7:0] skipCount;
  logic [6:0] stateOut;
  logic       rxArm;
  logic       txArm;
  notify_s    notify;
  int         errorCnt = 0;
  int         nChecks = 0;
  row_s       rows [29];

  pmbus_master_model u_master (.clk(clk), .sys_rst(sysRst), .evtReq(evtReq), .busEvt(busEvt),
    .startSeenFlag(startSeenFlag), .stopSeenFlag(stopSeenFlag));

  pmbus_slave_transfer_fsm u_dut (.clk(clk), .sys_rst(sysRst), .busEvt(busEvt), .startSeenFlag(startSeenFlag),
    .stopSeenFlag(stopSeenFlag), .sendReq(sendReq), .recvReq(recvReq), .reqLen(reqLen), .araMode(araMode),
    .dirTx(dirTx), .byteCount(byteCount), .skipCount(skipCount), .stateOut(stateOut), .rxArm(rxArm),
    .txArm(txArm), .notify(notify));

  // The clock toggles every half period of 2.5 ns.
  initial begin
    forever #2.5 clk = ~clk;
  end

  // One comparison, counted, with a report on mismatch.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    nChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic conclude();
    if (errorCnt == 0 && nChecks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Applies one row; all-ones notify, arm and count fields in the expectation mean the value is not compared.
  task automatic run(input row_s r);
    @(posedge clk);
    evtReq  <= r.ev;
    sendReq <= r.sra[2];
    recvReq <= r.sra[1];
    araMode <= r.sra[0];
    reqLen  <= r.len;
    @(posedge clk);
    evtReq  <= 8'h00;
    sendReq <= 1'b0;
    recvReq <= 1'b0;
    @(posedge clk);
    #1;
    if (r.nt != 8'hFF) chk(notify, r.nt);
    if (r.arm != 2'h3) chk({6'h00, rxArm, txArm}, {6'h00, r.arm});
    @(posedge clk);
    #1;
    chk({1'b0, stateOut}, {1'b0, r.st});
    chk({7'h00, dirTx}, {7'h00, r.dir});
    if (r.cnt != 8'hFF) chk(byteCount, r.cnt);
    chk(skipCount, 8'h00);
  endtask

  // Main sequence: table rows, then reset in mid-run and back-to-back bytes.
  initial begin
    rows = '{
      {8'h00,3'h2,8'h02,8'h00,2'h0,7'h01,1'h0,8'h00}, {8'h80,3'h0,8'h00,8'h08,2'h0,7'h02,1'h0,8'h00},
      {8'h20,3'h0,8'h00,8'h80,2'h0,7'h02,1'h0,8'h01}, {8'h20,3'h0,8'h00,8'h80,2'h0,7'h04,1'h0,8'h02},
      {8'h01,3'h0,8'h00,8'h00,2'h0,7'h04,1'h0,8'h02}, {8'h02,3'h0,8'h00,8'h05,2'h0,7'h04,1'h0,8'h02},
      {8'h20,3'h0,8'h00,8'h07,2'h0,7'h04,1'h0,8'h02},
      {8'h40,3'h0,8'h00,8'h40,2'h2,7'h01,1'h0,8'hFF}, {8'h00,3'h2,8'h23,8'h00,2'h0,7'h01,1'h0,8'h00},
      {8'h80,3'h0,8'h00,8'h08,2'h0,7'h02,1'h0,8'h00}, {8'h20,3'h0,8'h00,8'h80,2'h0,7'h02,1'h0,8'h01},
      {8'h40,3'h0,8'h00,8'h40,2'h2,7'h01,1'h0,8'hFF}, {8'h80,3'h0,8'h00,8'h08,2'h0,7'h02,1'h0,8'h00},
      {8'h10,3'h0,8'h00,8'h20,2'h0,7'h08,1'h1,8'h00}, {8'h00,3'h4,8'h01,8'h00,2'h0,7'h01,1'h1,8'hFF},
      {8'h80,3'h0,8'h00,8'h08,2'h0,7'h08,1'h1,8'h00}, {8'h10,3'h0,8'h00,8'hFF,2'h0,7'h08,1'h1,8'h01},
      {8'h10,3'h0,8'h00,8'hFF,2'h0,7'h10,1'h1,8'h01}, {8'h80,3'h0,8'h00,8'h07,2'h0,7'h10,1'h1,8'h01},
      {8'h08,3'h0,8'h00,8'hFF,2'h0,7'h20,1'h1,8'h01}, {8'h40,3'h0,8'h00,8'h10,2'h2,7'h20,1'h1,8'hFF},
      {8'h00,3'h4,8'h02,8'h00,2'h0,7'h01,1'h1,8'hFF}, {8'h80,3'h0,8'h00,8'h08,2'h0,7'h08,1'h1,8'h00},
      {8'h02,3'h0,8'h00,8'h05,2'h0,7'h08,1'h1,8'h00}, {8'h04,3'h1,8'h00,8'h16,2'h1,7'h08,1'h1,8'h00},
      {8'h00,3'h4,8'h01,8'h00,2'h0,7'h01,1'h1,8'hFF}, {8'h80,3'h0,8'h00,8'h08,2'h0,7'h08,1'h1,8'h00},
      {8'h10,3'h0,8'h00,8'hFF,2'h0,7'h08,1'h1,8'h01}, {8'h04,3'h0,8'h00,8'hFF,2'h3,7'h20,1'h1,8'h01}};
    repeat (8) @(posedge clk);
    sysRst <= 1'b0;
    foreach (rows[i]) begin
      run(rows[i]);
    end
    @(posedge clk);
    sysRst <= 1'b1;
    repeat (2) @(posedge clk);
    sysRst <= 1'b0;
    #1;
    chk({1'b0, stateOut}, 8'h01);
    chk({7'h00, dirTx}, 8'h00);
    chk(notify, 8'h00);
    run(rows[0]);
    run(rows[1]);
    @(posedge clk);
    evtReq <= 8'h20;
    repeat (2) @(posedge clk);
    evtReq <= 8'h00;
    repeat (3) @(posedge clk);
    #1;
    chk(byteCount, 8'h02);
    chk({1'b0, stateOut}, 8'h04);
    conclude();
  end
endmodule
